// >>> rcw_pkg.sv
// rcw_pkg: constants, register layouts and carrier types for the
// calendar clock calibration and waveform block.
// assumes a 125 MHz system clock and a one-cycle slow clock tick input.
`default_nettype none

package rcw_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_STATE = 8'h08;

  // writable bits and values after reset
  localparam logic [31:0] CTRL_WMASK = 32'h0003_0303;
  localparam logic [31:0] MODE_WMASK = 32'h0077_FF13;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;

  // slow clock divider and correction step (128 slow cycles, about 4 ms)
  localparam logic [15:0] SLOW_DIV = 16'h8000;
  localparam logic [15:0] CORR_STEP = 16'h0080;
  localparam logic [11:0] CORR_MULT_LOW = 12'h014;
  localparam logic [11:0] CORR_MULT_HIGH_CUT = 12'h013;

  // divider bit positions for the square waves
  localparam int BIT_1HZ = 14;
  localparam int BIT_32HZ = 9;
  localparam int BIT_64HZ = 8;
  localparam int BIT_512HZ = 5;

  // pulse timing: least time, rounded up to whole clock cycles
  localparam int CLK_PERIOD_NS = 8;
  localparam int PULSE_NS = 15000;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // waveform source codes
  localparam logic [2:0] SRC_ZERO = 3'h0;
  localparam logic [2:0] SRC_1HZ = 3'h1;
  localparam logic [2:0] SRC_32HZ = 3'h2;
  localparam logic [2:0] SRC_64HZ = 3'h3;
  localparam logic [2:0] SRC_512HZ = 3'h4;
  localparam logic [2:0] SRC_TOGGLE = 3'h5;
  localparam logic [2:0] SRC_ALARM = 3'h6;
  localparam logic [2:0] SRC_PULSE = 3'h7;

  // event selection codes
  localparam logic [1:0] TEV_MINUTE = 2'h0;
  localparam logic [1:0] TEV_HOUR = 2'h1;
  localparam logic [1:0] TEV_NOON = 2'h2;
  localparam logic [1:0] TEV_MIDNIGHT = 2'h3;
  localparam logic [1:0] CEV_WEEK = 2'h0;
  localparam logic [1:0] CEV_MONTH = 2'h1;
  localparam logic [1:0] CEV_YEAR = 2'h2;

  typedef struct packed {
    logic [13:0] unused2;
    logic [1:0] cal_event_sel;
    logic [5:0] unused1;
    logic [1:0] time_event_sel;
    logic [5:0] unused0;
    logic cal_update_req;
    logic time_update_req;
  } rcw_ctrl_t;

  typedef struct packed {
    logic [8:0] unused3;
    logic [2:0] wave_src_sel_b;
    logic unused2;
    logic [2:0] wave_src_sel_a;
    logic high_range_sel;
    logic [6:0] correction_value;
    logic [2:0] unused1;
    logic correction_sign;
    logic [1:0] unused0;
    logic persian;
    logic hour_format;
  } rcw_mode_t;

  typedef struct packed {
    logic minute;
    logic hour;
    logic noon;
    logic midnight;
  } rcw_time_chg_t;

  typedef struct packed {
    logic week;
    logic month;
    logic year;
  } rcw_cal_chg_t;

  typedef enum logic [2:0] {
    UPD_IDLE = 3'b001,
    UPD_WAIT = 3'b010,
    UPD_ACKED = 3'b100
  } rcw_upd_state_t;

endpackage

`default_nettype wire

// >>> rcw_top.sv
// rcw_top: slow clock divider with digital drift correction, two
// waveform outputs, control and mode registers, update handshake.
// assumes slow_tick_in pulses once per 32.768 kHz period and that the
// counters, alarm logic and status flags live in neighbouring blocks.
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module rcw_top #(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic slow_tick_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic write_protect_enable_in,
  input wire logic alarm_flag_in,
  input wire logic alarm_hit_in,
  input wire rcw_pkg::rcw_time_chg_t time_chg_in,
  input wire rcw_pkg::rcw_cal_chg_t cal_chg_in,
  output logic [31:0] rdata_out,
  output logic second_tick_out,
  output logic time_halt_out,
  output logic cal_halt_out,
  output logic update_ack_out,
  output logic time_event_out,
  output logic cal_event_out,
  output logic hour_format_out,
  output logic persian_out,
  output logic wave_out_a_out,
  output logic wave_oe_a_out,
  output logic wave_out_b_out,
  output logic wave_oe_b_out
);

  localparam logic [10:0] PULSE_LOAD = 11'(rcw_pkg::PULSE_CYC - 1);

  // correction interval in whole seconds
  function automatic logic [11:0] corr_interval(input logic high,
                                                input logic [6:0] value);
    logic [11:0] mult;
    mult = high ? (rcw_pkg::CORR_MULT_LOW - rcw_pkg::CORR_MULT_HIGH_CUT)
                : rcw_pkg::CORR_MULT_LOW;
    corr_interval = 12'(mult * {5'h00, value}) + 12'h001;
  endfunction

  // waveform source multiplexer shared by both outputs
  function automatic logic wave_pick(input logic [2:0] src,
                                     input logic [15:0] div,
                                     input logic [5:0] fast,
                                     input logic tog,
                                     input logic alarm,
                                     input logic pulse);
    case (src)
      rcw_pkg::SRC_ZERO: wave_pick = 1'b0;
      rcw_pkg::SRC_1HZ: wave_pick = div[rcw_pkg::BIT_1HZ];
      rcw_pkg::SRC_32HZ: wave_pick = div[rcw_pkg::BIT_32HZ];
      rcw_pkg::SRC_64HZ: wave_pick = div[rcw_pkg::BIT_64HZ];
      rcw_pkg::SRC_512HZ: wave_pick = fast[rcw_pkg::BIT_512HZ];
      rcw_pkg::SRC_TOGGLE: wave_pick = tog;
      rcw_pkg::SRC_ALARM: wave_pick = alarm;
      rcw_pkg::SRC_PULSE: wave_pick = pulse;
      default: wave_pick = 1'b0;
    endcase
  endfunction

  // register file state
  rcw_pkg::rcw_ctrl_t ctrl, next_ctrl;
  rcw_pkg::rcw_mode_t mode, next_mode;
  logic [31:0] next_rdata;

  // divider state
  logic [15:0] div_cnt, next_div_cnt;
  logic [5:0] fast_cnt, next_fast_cnt;
  logic [11:0] sec_cnt, next_sec_cnt;
  logic [15:0] div_limit;
  logic corr_now;
  logic wrap;
  logic next_second_tick;

  // waveform state
  logic tog, next_tog;
  logic pulse, next_pulse;
  logic [10:0] pulse_cnt, next_pulse_cnt;
  logic next_wave_a, next_wave_b;

  // update handshake and events
  rcw_pkg::rcw_upd_state_t upd_state, next_upd_state;
  logic next_time_event, next_cal_event;

  // register access; reset is the backup power-on reset, so settings
  // survive every other event and vanish only with backup power
  always_comb begin
    next_ctrl = ctrl;
    next_mode = mode;
    next_rdata = 32'h0000_0000;
    if (wr_in && !write_protect_enable_in) begin
      if (addr_in == ADDR_W'(rcw_pkg::OFS_CONTROL)) begin
        next_ctrl = rcw_pkg::rcw_ctrl_t'(wdata_in & rcw_pkg::CTRL_WMASK);
      end
      if (addr_in == ADDR_W'(rcw_pkg::OFS_MODE)) begin
        next_mode = rcw_pkg::rcw_mode_t'(wdata_in & rcw_pkg::MODE_WMASK);
      end
    end
    if (rd_in) begin
      if (addr_in == ADDR_W'(rcw_pkg::OFS_CONTROL)) begin
        next_rdata = ctrl;
      end else if (addr_in == ADDR_W'(rcw_pkg::OFS_MODE)) begin
        next_rdata = mode;
      end else if (addr_in == ADDR_W'(rcw_pkg::OFS_STATE)) begin
        next_rdata = {upd_state, corr_now, 12'h000, sec_cnt, 4'h0};
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl <= rcw_pkg::rcw_ctrl_t'(rcw_pkg::CTRL_RESET);
      mode <= rcw_pkg::rcw_mode_t'(rcw_pkg::MODE_RESET);
      rdata_out <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      mode <= next_mode;
      rdata_out <= next_rdata;
    end
  end

  assign corr_now = (mode.correction_value != 7'h00) &&
    (sec_cnt >= corr_interval(mode.high_range_sel,
                              mode.correction_value) - 12'h001);

  // one period stretched or cut by the step
  assign div_limit = !corr_now ? rcw_pkg::SLOW_DIV :
    mode.correction_sign ? rcw_pkg::SLOW_DIV - rcw_pkg::CORR_STEP
                         : rcw_pkg::SLOW_DIV + rcw_pkg::CORR_STEP;

  assign wrap = slow_tick_in && (div_cnt >= div_limit - 16'h0001);

  // only the derived tick is adjusted, the slow clock is just counted
  always_comb begin
    next_div_cnt = div_cnt;
    next_fast_cnt = fast_cnt;
    next_sec_cnt = sec_cnt;
    next_second_tick = 1'b0;
    if (slow_tick_in) begin
      next_fast_cnt = fast_cnt + 6'h01;
      next_div_cnt = div_cnt + 16'h0001;
    end
    if (wrap) begin
      next_div_cnt = 16'h0000;
      next_second_tick = 1'b1;
      if (corr_now || mode.correction_value == 7'h00) begin
        next_sec_cnt = 12'h000;
      end else begin
        next_sec_cnt = sec_cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt <= 16'h0000;
      fast_cnt <= 6'h00;
      sec_cnt <= 12'h000;
      second_tick_out <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      fast_cnt <= next_fast_cnt;
      sec_cnt <= next_sec_cnt;
      second_tick_out <= next_second_tick;
    end
  end

  // waveform sources; nothing here looks at power mode, so the outputs
  // run on through every low-power state
  always_comb begin
    next_tog = tog;
    next_pulse = pulse;
    next_pulse_cnt = pulse_cnt;
    if (alarm_hit_in) begin
      next_tog = !tog;
    end
    if (wrap) begin
      next_pulse = 1'b1;
      next_pulse_cnt = PULSE_LOAD;
    end else if (pulse_cnt != 11'h000) begin
      next_pulse_cnt = pulse_cnt - 11'h001;
    end else begin
      next_pulse = 1'b0;
    end
    // 512 Hz taken from the uncorrected counter
    next_wave_a = wave_pick(mode.wave_src_sel_a, div_cnt, fast_cnt,
                            tog, alarm_flag_in, pulse);
    next_wave_b = wave_pick(mode.wave_src_sel_b, div_cnt, fast_cnt,
                            tog, alarm_flag_in, pulse);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tog <= 1'b0;
      pulse <= 1'b0;
      pulse_cnt <= 11'h000;
      wave_out_a_out <= 1'b0;
      wave_out_b_out <= 1'b0;
      wave_oe_a_out <= 1'b0;
      wave_oe_b_out <= 1'b0;
    end else begin
      tog <= next_tog;
      pulse <= next_pulse;
      pulse_cnt <= next_pulse_cnt;
      wave_out_a_out <= next_wave_a;
      wave_out_b_out <= next_wave_b;
      wave_oe_a_out <= (mode.wave_src_sel_a != rcw_pkg::SRC_ZERO);
      wave_oe_b_out <= (mode.wave_src_sel_b != rcw_pkg::SRC_ZERO);
    end
  end

  // update handshake: acknowledge at the next second boundary so the
  // counters are loaded between ticks, never across one
  always_comb begin
    next_upd_state = upd_state;
    case (upd_state)
      rcw_pkg::UPD_IDLE: begin
        if (ctrl.time_update_req || ctrl.cal_update_req) begin
          next_upd_state = rcw_pkg::UPD_WAIT;
        end
      end
      rcw_pkg::UPD_WAIT: begin
        if (!ctrl.time_update_req && !ctrl.cal_update_req) begin
          next_upd_state = rcw_pkg::UPD_IDLE;
        end else if (wrap) begin
          next_upd_state = rcw_pkg::UPD_ACKED;
        end
      end
      rcw_pkg::UPD_ACKED: begin
        if (!ctrl.time_update_req && !ctrl.cal_update_req) begin
          next_upd_state = rcw_pkg::UPD_IDLE;
        end
      end
      default: next_upd_state = rcw_pkg::UPD_IDLE;
    endcase
  end

  always_comb begin
    case (ctrl.time_event_sel)
      rcw_pkg::TEV_MINUTE: next_time_event = time_chg_in.minute;
      rcw_pkg::TEV_HOUR: next_time_event = time_chg_in.hour;
      rcw_pkg::TEV_NOON: next_time_event = time_chg_in.noon;
      rcw_pkg::TEV_MIDNIGHT: next_time_event = time_chg_in.midnight;
      default: next_time_event = 1'b0;
    endcase
    case (ctrl.cal_event_sel)
      rcw_pkg::CEV_WEEK: next_cal_event = cal_chg_in.week;
      rcw_pkg::CEV_MONTH: next_cal_event = cal_chg_in.month;
      rcw_pkg::CEV_YEAR: next_cal_event = cal_chg_in.year;
      default: next_cal_event = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      upd_state <= rcw_pkg::UPD_IDLE;
      update_ack_out <= 1'b0;
      time_halt_out <= 1'b0;
      cal_halt_out <= 1'b0;
      time_event_out <= 1'b0;
      cal_event_out <= 1'b0;
      hour_format_out <= 1'b0;
      persian_out <= 1'b0;
    end else begin
      upd_state <= next_upd_state;
      update_ack_out <= (next_upd_state == rcw_pkg::UPD_ACKED) &&
        (next_ctrl.time_update_req || next_ctrl.cal_update_req);
      time_halt_out <= next_ctrl.time_update_req;
      // calendar halted; a time update stops the calendar too
      cal_halt_out <= next_ctrl.cal_update_req || next_ctrl.time_update_req;
      time_event_out <= next_time_event;
      cal_event_out <= next_cal_event;
      hour_format_out <= next_mode.hour_format;
      persian_out <= next_mode.persian;
    end
  end

  // checks
  wp_block_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (wr_in && write_protect_enable_in) |=> ($stable(ctrl) && $stable(mode)))
    else $error("register changed under write protect");

  corr_off_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (mode.correction_value == 7'h00) |-> (!corr_now &&
      div_limit == rcw_pkg::SLOW_DIV))
    else $error("correction active with zero value");

  corr_dir_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    corr_now |-> (mode.correction_sign ? (div_limit == 16'h7F80)
                                       : (div_limit == 16'h8080)))
    else $error("correction period length wrong");

  tick_wrap_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (slow_tick_in && div_cnt == div_limit - 16'h0001)
      |=> (second_tick_out && div_cnt == 16'h0000))
    else $error("second tick missed at divider end");

  src_zero_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (mode.wave_src_sel_a == rcw_pkg::SRC_ZERO) |=> !wave_out_a_out)
    else $error("output a not held low");

  alarm_copy_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (mode.wave_src_sel_b == rcw_pkg::SRC_ALARM)
      |=> (wave_out_b_out == $past(alarm_flag_in)))
    else $error("output b does not follow alarm flag");

  alarm_toggle_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (alarm_hit_in && mode.wave_src_sel_a == rcw_pkg::SRC_TOGGLE &&
      $stable(mode)) |=> ##1 (wave_out_a_out != $past(wave_out_a_out)))
    else $error("output a did not toggle on alarm");

  pulse_hold_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(pulse) |-> (pulse && pulse_cnt == PULSE_LOAD) [*1] ##1 pulse [*8])
    else $error("pulse ended too early");

  pulse_end_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (pulse && pulse_cnt == 11'h000 && !wrap) |=> !pulse)
    else $error("pulse ran past its length");

  pin_route_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    ##1 (wave_oe_b_out == ($past(mode.wave_src_sel_b) != 3'h0)))
    else $error("pin route does not match source");

  ack_req_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    update_ack_out |-> (time_halt_out || cal_halt_out))
    else $error("acknowledge without update request");

  time_ev_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (time_chg_in.midnight && ctrl.time_event_sel == rcw_pkg::TEV_MIDNIGHT)
      |=> time_event_out)
    else $error("selected time event not passed on");

endmodule

`default_nettype wire

// >>> tb_top.sv
// tb_top: self-checking bench for the calibration and waveform block.
// assumes registers at the package offsets and that a slow tick held high
// counts once per system clock, so one second lasts 32768 cycles here.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end

module tb_top;
  localparam int TIMEOUT = 90000;
  localparam int DIV = 32768;
  localparam int STEP = 128;
  // high range, value 1 for 1950 ppm, sign 0, a=1 Hz, b=pulse
  localparam logic [31:0] MEAS_MODE = 32'h0071_8100;
  // low range, 20 ppm gives value 9; no correction within the run
  localparam logic [31:0] LOW_MODE = 32'h0071_0900;

  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic slow_tick_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic write_protect_enable_in = 1'b0;
  logic alarm_flag_in = 1'b0;
  logic alarm_hit_in = 1'b0;
  rcw_pkg::rcw_time_chg_t time_chg_in = '0;
  rcw_pkg::rcw_cal_chg_t cal_chg_in = '0;
  logic [31:0] rdata_out;
  logic second_tick_out, time_halt_out, cal_halt_out, update_ack_out;
  logic time_event_out, cal_event_out, hour_format_out, persian_out;
  logic wave_out_a_out, wave_oe_a_out, wave_out_b_out, wave_oe_b_out;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;

  always #4 sys_clk_in = ~sys_clk_in;

  rcw_top #(.ADDR_W(8)) DUT (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .slow_tick_in(slow_tick_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .write_protect_enable_in(write_protect_enable_in),
    .alarm_flag_in(alarm_flag_in),
    .alarm_hit_in(alarm_hit_in),
    .time_chg_in(time_chg_in),
    .cal_chg_in(cal_chg_in),
    .rdata_out(rdata_out),
    .second_tick_out(second_tick_out),
    .time_halt_out(time_halt_out),
    .cal_halt_out(cal_halt_out),
    .update_ack_out(update_ack_out),
    .time_event_out(time_event_out),
    .cal_event_out(cal_event_out),
    .hour_format_out(hour_format_out),
    .persian_out(persian_out),
    .wave_out_a_out(wave_out_a_out),
    .wave_oe_a_out(wave_oe_a_out),
    .wave_out_b_out(wave_out_b_out),
    .wave_oe_b_out(wave_oe_b_out)
  );

  task automatic print_verdict;
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask

  // read data is only valid in the single cycle after the strobe edge
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    `CHK(rdata_out, exp)
  endtask

  task automatic pulse_chg(input int j);
    @(posedge sys_clk_in);
    time_chg_in <= rcw_pkg::rcw_time_chg_t'(4'h8 >> j);
    cal_chg_in <= rcw_pkg::rcw_cal_chg_t'((j < 3) ? (3'h4 >> j) : 3'h0);
    @(posedge sys_clk_in);
    time_chg_in <= '0;
    cal_chg_in <= '0;
    #1;
  endtask

  // a hang is cut short here and still reaches the single verdict
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT) begin
      fail_count++;
      $display("Error at %0t: timeout", $time);
      print_verdict();
    end
  end

  initial begin : main
    logic tog;
    int ticks, per, run_a, run_b, na, pw, win, hi, lo_a;
    int runs_a[2];
    repeat (8) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    wait_cyc(2);
    `CHK(wave_oe_a_out, 1'b0)
    `CHK(wave_out_b_out, 1'b0)
    rd_chk(rcw_pkg::OFS_CONTROL, rcw_pkg::CTRL_RESET);
    rd_chk(rcw_pkg::OFS_MODE, rcw_pkg::MODE_RESET);
    reg_wr(rcw_pkg::OFS_MODE, 32'hFFFF_FFFF);
    rd_chk(rcw_pkg::OFS_MODE, rcw_pkg::MODE_WMASK);
    `CHK(hour_format_out, 1'b1)
    @(posedge sys_clk_in);
    write_protect_enable_in <= 1'b1;
    reg_wr(rcw_pkg::OFS_MODE, 32'h0000_0000);
    reg_wr(rcw_pkg::OFS_CONTROL, 32'h0000_0001);
    rd_chk(rcw_pkg::OFS_MODE, rcw_pkg::MODE_WMASK);
    rd_chk(rcw_pkg::OFS_CONTROL, 32'h0000_0000);
    @(posedge sys_clk_in);
    write_protect_enable_in <= 1'b0;
    reg_wr(rcw_pkg::OFS_MODE, 32'h0000_0002);
    reg_wr(8'h40, 32'hFFFF_FFFF);
    rd_chk(rcw_pkg::OFS_MODE, 32'h0000_0002);
    rd_chk(8'h40, 32'h0000_0000);
    `CHK(hour_format_out, 1'b0)
    `CHK(persian_out, 1'b1)
    reg_wr(rcw_pkg::OFS_CONTROL, 32'hFFFF_FFFF);
    rd_chk(rcw_pkg::OFS_CONTROL, rcw_pkg::CTRL_WMASK);
    `CHK(time_halt_out, 1'b1)
    reg_wr(rcw_pkg::OFS_CONTROL, 32'h0000_0002);
    wait_cyc(1);
    `CHK(time_halt_out, 1'b0)
    `CHK(cal_halt_out, 1'b1)
    // every selection against every change source; cal code 3 selects none
    for (int i = 0; i < 4; i++) begin
      reg_wr(rcw_pkg::OFS_CONTROL, {14'h0, i[1:0], 6'h0, i[1:0], 8'h00});
      for (int j = 0; j < 4; j++) begin
        pulse_chg(j);
        `CHK(time_event_out, 1'(i == j))
        `CHK(cal_event_out, 1'(i == j && j < 3))
      end
    end
    reg_wr(rcw_pkg::OFS_MODE, 32'h0066_0000);
    @(posedge sys_clk_in);
    alarm_flag_in <= 1'b1;
    wait_cyc(3);
    `CHK(wave_out_a_out, 1'b1)
    `CHK(wave_out_b_out, 1'b1)
    `CHK(wave_oe_a_out, 1'b1)
    @(posedge sys_clk_in);
    alarm_flag_in <= 1'b0;
    wait_cyc(3);
    `CHK(wave_out_a_out, 1'b0)
    `CHK(wave_out_b_out, 1'b0)
    reg_wr(rcw_pkg::OFS_MODE, 32'h0005_0000);
    wait_cyc(3);
    tog = wave_out_a_out;
    @(posedge sys_clk_in);
    alarm_hit_in <= 1'b1;
    @(posedge sys_clk_in);
    alarm_hit_in <= 1'b0;
    wait_cyc(3);
    `CHK(wave_out_a_out, ~tog)
    reg_wr(rcw_pkg::OFS_MODE, 32'h0000_0000);
    wait_cyc(3);
    `CHK(wave_out_a_out, 1'b0)
    `CHK(wave_oe_a_out, 1'b0)
    // update request armed before the divider runs, acked at first wrap
    reg_wr(rcw_pkg::OFS_CONTROL, 32'h0000_0001);
    reg_wr(rcw_pkg::OFS_MODE, MEAS_MODE);
    wait_cyc(2);
    `CHK(wave_oe_b_out, 1'b1)
    `CHK(update_ack_out, 1'b0)
    @(posedge sys_clk_in);
    slow_tick_in <= 1'b1;
    ticks = 0;
    per = 0;
    na = 0;
    pw = 0;
    run_a = 0;
    run_b = 0;
    lo_a = 0;
    // run lengths are measured so that output latency does not matter;
    // the corrected second shows up as a longer low half of the 1 Hz wave
    while (ticks < 2 || na < 2 || wave_out_a_out !== 1'b1) begin
      @(posedge sys_clk_in);
      #1;
      per++;
      if (wave_out_a_out === 1'b1) begin
        run_a++;
      end else if (run_a > 0) begin
        if (na < 2) begin
          runs_a[na] = run_a;
        end
        na++;
        run_a = 0;
      end
      if (na == 2 && wave_out_a_out !== 1'b1) begin
        lo_a++;
      end
      if (wave_out_b_out === 1'b1) begin
        run_b++;
      end else if (run_b > 0 && pw == 0) begin
        pw = run_b;
      end
      if (second_tick_out === 1'b1) begin
        if (ticks == 1) begin
          `CHK(per, DIV + STEP)
        end
        ticks++;
        per = 0;
      end
    end
    `CHK(runs_a[0], DIV / 2)
    `CHK(runs_a[1], DIV / 2)
    `CHK(lo_a, DIV / 2 + STEP)
    `CHK(pw, 15000 / 8)
    `CHK(update_ack_out, 1'b1)
    `CHK(time_halt_out, 1'b1)
    reg_wr(rcw_pkg::OFS_CONTROL, 32'h0000_0000);
    wait_cyc(2);
    `CHK(update_ack_out, 1'b0)
    `CHK(time_halt_out, 1'b0)
    // one full period of the 32 Hz, 64 Hz and 512 Hz square waves must be exactly half high
    for (int k = 2; k <= 4; k++) begin
      win = (k == 2) ? 1024 : ((k == 3) ? 512 : 64);
      reg_wr(rcw_pkg::OFS_MODE, (LOW_MODE & 32'hFFF8_FFFF) | 32'(k << 16));
      wait_cyc(4);
      hi = 0;
      repeat (win) begin
        @(posedge sys_clk_in);
        #1;
        if (wave_out_a_out === 1'b1) begin
          hi++;
        end
      end
      `CHK(hi, win / 2)
    end
    print_verdict();
  end
endmodule

`default_nettype wire
